// ===== logic/sbt_pkg.sv
// Constants and carrier types of the SRAM boundary scan test port
package sbt_pkg;

    // ----------------------------------------------------------------
    // Register sizes and positions
    // ----------------------------------------------------------------
    localparam int          IR_LEN       = 3;
    localparam int          ID_LEN       = 32;
    localparam int          BSR_LEN      = 107;
    localparam int          OE_CELL      = 47;
    localparam int          TMS_RST_CNT  = 5;

    // ----------------------------------------------------------------
    // Instruction codes
    // ----------------------------------------------------------------
    localparam logic [2:0]  INS_EXTEST   = 3'h0;
    localparam logic [2:0]  INS_IDCODE   = 3'h1;
    localparam logic [2:0]  INS_SAMPLE_Z = 3'h2;
    localparam logic [2:0]  INS_SAMPLE   = 3'h4;
    localparam logic [2:0]  INS_BYPASS   = 3'h7;

    // ----------------------------------------------------------------
    // Capture and reset values
    // ----------------------------------------------------------------
    localparam logic [2:0]  IR_CAPTURE   = 3'h1;
    localparam logic [2:0]  IR_RESET     = INS_IDCODE;
    localparam logic        BYP_CAPTURE  = 1'h0;
    localparam logic        OE_CELL_RST  = 1'h0;
    // Arbitrary identification value, bit 0 marks presence
    localparam logic [31:0] ID_DEFAULT   = 32'h5A5A_A001;

    // ----------------------------------------------------------------
    // Controller states and pin carriers
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
        ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR,
        ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } sbt_state_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } sbt_tap_in_t;

    typedef struct packed {
        logic tdo;
        logic tdo_oe;
    } sbt_tap_out_t;

endpackage

// ===== logic/sbt_tap.sv
// Boundary scan test access port of a synchronous SRAM
`timescale 1ns/10ps
// Overview of operation
// [RQ1] Serial output changes on test clock falls; inputs sampled on rises.
// [RQ2] Serial output shows the selected register's least significant bit.
// [RQ3] Serial input enters the selected register's most significant bit.
// [RQ4] Controller resets the port by five test clock rises with mode high.
// [RQ5] Port resets at power-up with output floating; memory is untouched.
// [RQ6] Exactly one register sits between serial input and output.
// [RQ7] Three-bit instruction register holds identification after any reset.
// [RQ8] Capture-IR loads pattern 01 into the two low shift bits.
// [RQ9] Instructions shift in Shift-IR and act only at Update-IR.
// [RQ10] Controller never loads the three reserved instruction codes; here Update-IR loads them and they select bypass.
// [RQ11] Codes: 000 extest, 001 ident, 010 float sample, 100 sample, 111 bypass.
// [RQ12] Bypass is one bit cleared when the bypass instruction runs.
// [RQ13] Bypass instruction puts the one-bit stage in the Shift-DR path.
// [RQ14] Identification Capture-DR loads the fixed 32-bit code for shifting.
// [RQ15] Boundary register captures pin cells at Capture-DR, shifts in Shift-DR.
// [RQ16] Float sample selects boundary register and floats outputs until Update-IR.
// [RQ17] Sample instruction snapshots pin values at Capture-DR.
// [RQ18] Preload latches shifted pattern onto boundary parallel outputs.
// [RQ19] Sampled data shifts out while preload data shifts in.
// [RQ20] Extest drives preloaded cells to outputs, boundary register in path.
// [RQ21] Cell 47 latched at Update-DR enables read drivers under extest.
// [RQ22] Output-control cell presets low at power-up and in Test-Logic-Reset.
// [RQ23] Controller keeps the test clock at or below 20 MHz.
// [RQ24] Sixteen-state controller advances by mode input on test clock rises.
module sbt_tap #(
    parameter int          BSR_W = sbt_pkg::BSR_LEN,
    parameter logic [31:0] ID_VAL = sbt_pkg::ID_DEFAULT
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Test port pins
    input  wire sbt_pkg::sbt_tap_in_t tap_in,
    output sbt_pkg::sbt_tap_out_t     tap_out,
    // Boundary ring
    input  wire logic [BSR_W-1:0]     ring_in,
    output logic      [BSR_W-1:0]     ring_out,
    output logic                      ring_drive,
    output logic                      q_bus_oe
);

    // ----------------------------------------------------------------
    // Pin synchronisers and test clock edges
    // ----------------------------------------------------------------
    sbt_pkg::sbt_tap_in_t  pin_s1;
    sbt_pkg::sbt_tap_in_t  pin_s2;
    logic                  tck_q;
    logic [BSR_W-1:0]      ring_s1;
    logic [BSR_W-1:0]      ring_s2;
    logic                  tck_rise;
    logic                  tck_fall;

    always_ff @(posedge clk)
    begin
        pin_s1  <= tap_in;
        pin_s2  <= pin_s1;
        ring_s1 <= ring_in;
        ring_s2 <= ring_s1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            tck_q <= 1'h0;
        else
            tck_q <= pin_s2.tck;
    end

    assign tck_rise = pin_s2.tck & ~tck_q;
    assign tck_fall = ~pin_s2.tck & tck_q;

    // ----------------------------------------------------------------
    // Controller state machine
    // ----------------------------------------------------------------
    sbt_pkg::sbt_state_t state;
    sbt_pkg::sbt_state_t next_state;
    logic                tms;

    assign tms = pin_s2.tms;

    always_comb
    begin
        unique case (state)
            sbt_pkg::ST_RESET:    next_state = tms ? sbt_pkg::ST_RESET    : sbt_pkg::ST_IDLE;
            sbt_pkg::ST_IDLE:     next_state = tms ? sbt_pkg::ST_SEL_DR   : sbt_pkg::ST_IDLE;
            sbt_pkg::ST_SEL_DR:   next_state = tms ? sbt_pkg::ST_SEL_IR   : sbt_pkg::ST_CAP_DR;
            sbt_pkg::ST_CAP_DR:   next_state = tms ? sbt_pkg::ST_EXIT1_DR : sbt_pkg::ST_SHIFT_DR;
            sbt_pkg::ST_SHIFT_DR: next_state = tms ? sbt_pkg::ST_EXIT1_DR : sbt_pkg::ST_SHIFT_DR;
            sbt_pkg::ST_EXIT1_DR: next_state = tms ? sbt_pkg::ST_UPD_DR   : sbt_pkg::ST_PAUSE_DR;
            sbt_pkg::ST_PAUSE_DR: next_state = tms ? sbt_pkg::ST_EXIT2_DR : sbt_pkg::ST_PAUSE_DR;
            sbt_pkg::ST_EXIT2_DR: next_state = tms ? sbt_pkg::ST_UPD_DR   : sbt_pkg::ST_SHIFT_DR;
            sbt_pkg::ST_UPD_DR:   next_state = tms ? sbt_pkg::ST_SEL_DR   : sbt_pkg::ST_IDLE;
            sbt_pkg::ST_SEL_IR:   next_state = tms ? sbt_pkg::ST_RESET    : sbt_pkg::ST_CAP_IR;
            sbt_pkg::ST_CAP_IR:   next_state = tms ? sbt_pkg::ST_EXIT1_IR : sbt_pkg::ST_SHIFT_IR;
            sbt_pkg::ST_SHIFT_IR: next_state = tms ? sbt_pkg::ST_EXIT1_IR : sbt_pkg::ST_SHIFT_IR;
            sbt_pkg::ST_EXIT1_IR: next_state = tms ? sbt_pkg::ST_UPD_IR   : sbt_pkg::ST_PAUSE_IR;
            sbt_pkg::ST_PAUSE_IR: next_state = tms ? sbt_pkg::ST_EXIT2_IR : sbt_pkg::ST_PAUSE_IR;
            sbt_pkg::ST_EXIT2_IR: next_state = tms ? sbt_pkg::ST_UPD_IR   : sbt_pkg::ST_SHIFT_IR;
            sbt_pkg::ST_UPD_IR:   next_state = tms ? sbt_pkg::ST_SEL_DR   : sbt_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            state <= sbt_pkg::ST_RESET;                         // RQ5
        else if (tck_rise)
            state <= next_state;                                // RQ24 RQ4
    end

    // ----------------------------------------------------------------
    // Instruction register
    // ----------------------------------------------------------------
    logic [sbt_pkg::IR_LEN-1:0] ir_sh;
    logic [sbt_pkg::IR_LEN-1:0] ir;

    always_ff @(posedge clk)
    begin
        if (rst)
            ir_sh <= sbt_pkg::IR_CAPTURE;
        else if (tck_rise && state == sbt_pkg::ST_CAP_IR)
            ir_sh <= sbt_pkg::IR_CAPTURE;                       // RQ8
        else if (tck_rise && state == sbt_pkg::ST_SHIFT_IR)
            ir_sh <= {pin_s2.tdi, ir_sh[sbt_pkg::IR_LEN-1:1]};  // RQ3
    end

    always_ff @(posedge clk)
    begin
        if (rst || state == sbt_pkg::ST_RESET)
            ir <= sbt_pkg::IR_RESET;                            // RQ7
        else if (tck_rise && state == sbt_pkg::ST_UPD_IR)
            ir <= ir_sh;                                        // RQ9
    end

    // ----------------------------------------------------------------
    // Data registers
    // ----------------------------------------------------------------
    logic               byp;
    logic [31:0]        id_sh;
    logic [BSR_W-1:0]   bsr_sh;
    logic               bsr_sel;
    logic               dr_cap;
    logic               dr_shift;

    // Reserved codes fall back to bypass
    assign bsr_sel  = (ir == sbt_pkg::INS_EXTEST) || (ir == sbt_pkg::INS_SAMPLE_Z)
                      || (ir == sbt_pkg::INS_SAMPLE);                 // RQ11
    assign dr_cap   = tck_rise && state == sbt_pkg::ST_CAP_DR;
    assign dr_shift = tck_rise && state == sbt_pkg::ST_SHIFT_DR;

    always_ff @(posedge clk)
    begin
        if (rst)
            byp <= sbt_pkg::BYP_CAPTURE;
        else if (dr_cap && !bsr_sel && ir != sbt_pkg::INS_IDCODE)
            byp <= sbt_pkg::BYP_CAPTURE;                        // RQ12
        else if (dr_shift && !bsr_sel && ir != sbt_pkg::INS_IDCODE)
            byp <= pin_s2.tdi;                                  // RQ13
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            id_sh <= ID_VAL;
        else if (dr_cap && ir == sbt_pkg::INS_IDCODE)
            id_sh <= ID_VAL;                                    // RQ14
        else if (dr_shift && ir == sbt_pkg::INS_IDCODE)
            id_sh <= {pin_s2.tdi, id_sh[31:1]};                 // RQ3
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            bsr_sh <= '0;
        else if (dr_cap && bsr_sel)
            bsr_sh <= ring_s2;                                  // RQ15 RQ17
        else if (dr_shift && bsr_sel)
            bsr_sh <= {pin_s2.tdi, bsr_sh[BSR_W-1:1]};          // RQ19 RQ3
    end

    // ----------------------------------------------------------------
    // Preload stage and output control
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst || state == sbt_pkg::ST_RESET)
            ring_out[sbt_pkg::OE_CELL] <= sbt_pkg::OE_CELL_RST; // RQ22
        else if (tck_rise && state == sbt_pkg::ST_UPD_DR && bsr_sel)
            ring_out[sbt_pkg::OE_CELL] <= bsr_sh[sbt_pkg::OE_CELL]; // RQ21
    end

    genvar g;
    generate
        for (g = 0; g < BSR_W; g++)
        begin : g_cell
            if (g != sbt_pkg::OE_CELL)
            begin : g_plain
                always_ff @(posedge clk)
                begin
                    if (rst)
                        ring_out[g] <= 1'h0;
                    else if (tck_rise && state == sbt_pkg::ST_UPD_DR && bsr_sel)
                        ring_out[g] <= bsr_sh[g];               // RQ18
                end
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ring_drive <= 1'h0;
            q_bus_oe   <= 1'h1;
        end
        else
        begin
            ring_drive <= (ir == sbt_pkg::INS_EXTEST);          // RQ20
            if (ir == sbt_pkg::INS_EXTEST)
                q_bus_oe <= ring_out[sbt_pkg::OE_CELL];         // RQ21
            else
                q_bus_oe <= (ir != sbt_pkg::INS_SAMPLE_Z);      // RQ16
        end
    end

    // ----------------------------------------------------------------
    // Serial output
    // ----------------------------------------------------------------
    logic sel_lsb;

    always_comb
    begin
        if (state == sbt_pkg::ST_SHIFT_IR)
            sel_lsb = ir_sh[0];                                 // RQ6
        else if (bsr_sel)
            sel_lsb = bsr_sh[0];
        else if (ir == sbt_pkg::INS_IDCODE)
            sel_lsb = id_sh[0];
        else
            sel_lsb = byp;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tap_out.tdo    <= 1'h0;
            tap_out.tdo_oe <= 1'h0;                             // RQ5
        end
        else if (tck_fall)
        begin
            tap_out.tdo    <= sel_lsb;                          // RQ1 RQ2
            tap_out.tdo_oe <= (state == sbt_pkg::ST_SHIFT_IR) || (state == sbt_pkg::ST_SHIFT_DR);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [2:0] tms_cnt;

    always_ff @(posedge clk)
    begin
        if (rst)
            tms_cnt <= 3'h0;
        else if (tck_rise)
            tms_cnt <= !tms ? 3'h0 : (tms_cnt == 3'h7 ? tms_cnt : tms_cnt + 3'h1);
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_tdo_on_fall:     assert property ($changed(tap_out.tdo) |-> $past(tck_fall))  // RQ1
        else $error("Serial output changed without a test clock fall");
    a_tdo_lsb:         assert property (tck_fall |=> tap_out.tdo == $past(sel_lsb)) // RQ2
        else $error("Serial output is not the selected lsb");
    a_tms_reset:       assert property (tms_cnt >= 3'(sbt_pkg::TMS_RST_CNT) |-> state == sbt_pkg::ST_RESET) // RQ4
        else $error("Five mode-high rises did not reset the controller");
    a_ir_reset_val:    assert property (state == sbt_pkg::ST_RESET |=> ir == sbt_pkg::INS_IDCODE) // RQ7
        else $error("Instruction not identification after reset state");
    a_ir_capture:      assert property (tck_rise && state == sbt_pkg::ST_CAP_IR |=> ir_sh[1:0] == 2'h1) // RQ8
        else $error("Capture-IR pattern wrong");
    a_ir_update_only:  assert property ($changed(ir) |-> $past(state == sbt_pkg::ST_UPD_IR && tck_rise)
                                         || $past(state) == sbt_pkg::ST_RESET) // RQ9
        else $error("Instruction changed outside Update-IR");
    a_bypass_clear:    assert property (dr_cap && ir == sbt_pkg::INS_BYPASS |=> !byp) // RQ12
        else $error("Bypass not cleared at capture");
    a_id_capture:      assert property (dr_cap && ir == sbt_pkg::INS_IDCODE |=> id_sh == ID_VAL) // RQ14
        else $error("Identification code not captured");
    a_ring_capture:    assert property (dr_cap && bsr_sel |=> bsr_sh == $past(ring_s2)) // RQ15
        else $error("Boundary capture mismatch");
    a_float_hold:      assert property (ir == sbt_pkg::INS_SAMPLE_Z |=> !q_bus_oe) // RQ16
        else $error("Outputs not floated under float sample");
    a_oe_cell_extest:  assert property (ir == sbt_pkg::INS_EXTEST |=> q_bus_oe == $past(ring_out[sbt_pkg::OE_CELL])) // RQ21
        else $error("Output enable does not follow cell 47");
    a_oe_cell_reset:   assert property (state == sbt_pkg::ST_RESET |=> !ring_out[sbt_pkg::OE_CELL]) // RQ22
        else $error("Output-control cell not preset low");

    c_id_shift:  cover property (ir == sbt_pkg::INS_IDCODE && dr_shift);
    c_byp_shift: cover property (ir == sbt_pkg::INS_BYPASS && dr_shift);
    c_extest_oe: cover property (ring_drive && q_bus_oe);
    c_ir_load:   cover property (tck_rise && state == sbt_pkg::ST_UPD_IR);

endmodule // sbt_tap

// ===== test/sbt_jtag_ctl.sv
// Board test controller model that drives the serial test port
`timescale 1ns/10ps
module sbt_jtag_ctl (
    // Clock
    input  wire logic                  clk,
    // Test port pins
    output sbt_pkg::sbt_tap_in_t       tap_in,
    input  wire sbt_pkg::sbt_tap_out_t tap_out
);
    // ----------------------------------------------------------------
    // Link idle: clock still and low, mode and data at pull-up level
    // ----------------------------------------------------------------
    initial tap_in = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};

    task automatic park();
        @(posedge clk);
        tap_in <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
    endtask

    // ----------------------------------------------------------------
    // One test clock period: 200 ns low, 120 ns high
    // ----------------------------------------------------------------
    task automatic tick(input logic tms_v, input logic tdi_v, output logic tdo_v, output logic oe_v);
        @(posedge clk);
        tap_in <= '{tck: 1'b0, tms: tms_v, tdi: tdi_v};
        repeat (4) @(posedge clk);
        @(posedge clk);
        tdo_v = tap_out.tdo;
        oe_v  = tap_out.tdo_oe;
        tap_in.tck <= 1'b1;
        repeat (2) @(posedge clk);
    endtask

    // Five rises with mode high, then Run-Test/Idle
    task automatic tres();
        logic t;
        logic o;
        repeat (5) tick(1'b1, 1'b1, t, o);
        tick(1'b0, 1'b1, t, o);
        park();
    endtask

    // From Idle through capture, shift and update of IR or DR
    task automatic scan(input logic ir_sel, input int n, input logic [127:0] din,
                        output logic [127:0] dout, output logic oe_all);
        logic t;
        logic o;
        dout   = '0;
        oe_all = 1'b1;
        tick(1'b1, 1'b1, t, o);
        if (ir_sel)
            tick(1'b1, 1'b1, t, o);
        tick(1'b0, 1'b1, t, o);
        tick(1'b0, 1'b1, t, o);
        for (int i = 0; i < n; i++)
        begin
            tick(i == n - 1, din[i], t, o);
            dout[i] = t;
            oe_all  = oe_all & o;
        end
        tick(1'b1, 1'b1, t, o);
        tick(1'b0, 1'b1, t, o);
        park();
    endtask
endmodule // sbt_jtag_ctl

// ===== test/tb_sbt_tap.sv
// Self-checking bench of the boundary scan test port
`timescale 1ns/10ps
module tb_sbt_tap;
    logic                          clk;
    logic                          rst;
    sbt_pkg::sbt_tap_in_t          tap_in;
    sbt_pkg::sbt_tap_out_t         tap_out;
    logic [sbt_pkg::BSR_LEN-1:0]   ring_in;
    logic [sbt_pkg::BSR_LEN-1:0]   ring_out;
    logic                          ring_drive;
    logic                          q_bus_oe;
    logic [sbt_pkg::BSR_LEN-1:0]   ring_exp = '0;
    logic [15:0]                   lfsr     = 16'hD1AC;
    logic                          tdo_q    = 1'b0;
    int                            lo_cnt   = 0;
    int                            n_errors = 0;
    int                            compares = 0;

    // ----------------------------------------------------------------
    // Clock, reset, instances
    // ----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial rst = 1'b1;
    initial ring_in = '0;

    sbt_tap sbt_tap_inst (.clk(clk), .rst(rst), .tap_in(tap_in), .tap_out(tap_out), .ring_in(ring_in),
                          .ring_out(ring_out), .ring_drive(ring_drive), .q_bus_oe(q_bus_oe));
    sbt_jtag_ctl sbt_jtag_ctl_inst (.clk(clk), .tap_in(tap_in), .tap_out(tap_out));

    // ----------------------------------------------------------------
    // Compare, random and expectation helpers
    // ----------------------------------------------------------------
    task automatic chk_vec(input string what, input logic [127:0] seen, input logic [127:0] want);
        compares++;
        if (seen !== want)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic chk_bit(input string what, input logic seen, input logic want);
        compares++;
        if (seen !== want)
        begin
            n_errors++;
            $display("unexpected %s: expected %b seen %b", what, want, seen);
        end
    endtask

    function automatic logic [127:0] rnd128();
        logic [127:0] v;
        v = '0;
        for (int i = 0; i < 8; i++)
        begin
            lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
            v    = {v[111:0], lfsr};
        end
        return v;
    endfunction

    // Only implemented instruction codes are ever loaded
    function automatic logic [2:0] legal_code(input int k);
        case (k % 5)
            0:       return sbt_pkg::INS_EXTEST;
            1:       return sbt_pkg::INS_BYPASS;
            2:       return sbt_pkg::INS_SAMPLE;
            3:       return sbt_pkg::INS_IDCODE;
            default: return sbt_pkg::INS_SAMPLE_Z;
        endcase
    endfunction

    function automatic logic is_bsr(input logic [2:0] code);
        return code == sbt_pkg::INS_EXTEST || code == sbt_pkg::INS_SAMPLE || code == sbt_pkg::INS_SAMPLE_Z;
    endfunction

    function automatic logic [127:0] exp_dr(input logic [2:0] code, input logic [127:0] din,
                                            input logic [sbt_pkg::BSR_LEN-1:0] cap);
        if (is_bsr(code))
            return (din << sbt_pkg::BSR_LEN) | 128'(cap);
        if (code == sbt_pkg::INS_IDCODE)
            return (din << sbt_pkg::ID_LEN) | 128'(sbt_pkg::ID_DEFAULT);
        return din << 1;
    endfunction

    // Serial output may move only late in the low phase of the test clock
    always @(posedge clk)
    begin
        if (!rst && tap_out.tdo !== tdo_q)
            chk_bit("tdo_timing", !(tap_in.tck || lo_cnt < 2), 1'b1);
        tdo_q  <= tap_out.tdo;
        lo_cnt <= tap_in.tck ? 0 : lo_cnt + 1;
    end

    // ----------------------------------------------------------------
    // Data register scan with fresh pin values and random shift data
    // ----------------------------------------------------------------
    task automatic dr_test(input logic [2:0] code, input logic cell_v);
        logic [127:0] din;
        logic [127:0] dout;
        logic [127:0] pins;
        logic         oe;
        din  = rnd128();
        pins = rnd128();
        din[sbt_pkg::OE_CELL + 21] = cell_v;
        @(posedge clk);
        ring_in <= pins[sbt_pkg::BSR_LEN-1:0];
        sbt_jtag_ctl_inst.scan(1'b0, 128, din, dout, oe);
        chk_vec("dr_data", dout, exp_dr(code, din, ring_in));
        chk_bit("tdo_oe_shift", oe, 1'b1);
        repeat (2) @(negedge clk);
        if (is_bsr(code))
            ring_exp = din[127:21];
        chk_vec("ring_out", 128'(ring_out), 128'(ring_exp));
        chk_bit("ring_drive", ring_drive, code == sbt_pkg::INS_EXTEST);
        chk_bit("q_bus_oe", q_bus_oe, code == sbt_pkg::INS_EXTEST ? ring_exp[sbt_pkg::OE_CELL] :
                code != sbt_pkg::INS_SAMPLE_Z);
        $display("test dr code %b done", code);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        logic [127:0] dout;
        logic [2:0]   code;
        logic         oe;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk_bit("tdo_oe_reset", tap_out.tdo_oe, 1'b0);
        chk_bit("ring_drive_reset", ring_drive, 1'b0);
        chk_bit("q_bus_oe_reset", q_bus_oe, 1'b1);
        chk_bit("cell_reset", ring_out[sbt_pkg::OE_CELL], 1'b0);
        sbt_jtag_ctl_inst.tres();
        dr_test(sbt_pkg::INS_IDCODE, 1'b0);
        for (int k = 0; k < 16; k++)
        begin
            code = legal_code(k);
            sbt_jtag_ctl_inst.scan(1'b1, sbt_pkg::IR_LEN, 128'(code), dout, oe);
            chk_vec("ir_capture", dout, 128'(sbt_pkg::IR_CAPTURE));
            dr_test(code, k[3]);
        end
        sbt_jtag_ctl_inst.tres();
        @(posedge clk);
        chk_bit("cell_preset", ring_out[sbt_pkg::OE_CELL], 1'b0);
        chk_bit("q_bus_oe_tlr", q_bus_oe, 1'b1);
        ring_exp[sbt_pkg::OE_CELL] = 1'b0;
        dr_test(sbt_pkg::INS_IDCODE, 1'b1);
        end_sim();
    end

    initial
    begin
        #2_400_000;
        n_errors++;
        end_sim();
    end

    task automatic end_sim();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
endmodule // tb_sbt_tap
